// ==== include/igf_pkg.sv ====
`default_nettype none
package igf_pkg;
	// ==========================================================
	// Request pair encodings, (flush, memory), active low.
	localparam logic [1:0] PAIR_IDLE     = 2'h3;
	localparam logic [1:0] PAIR_FLUSH    = 2'h1;
	localparam logic [1:0] PAIR_RESERVED = 2'h2;
	localparam logic [1:0] PAIR_GUARANTEED = 2'h0;
	// ==========================================================
	// Reset, inactive and active levels.
	localparam logic REQ_INACTIVE = 1'h1;
	localparam logic SEL_INACTIVE = 1'h1;
	localparam logic SEL_ACTIVE   = 1'h0;
	// ==========================================================
	// Width of a decoded PCI address.
	localparam int ADDR_W = 32;
	// ==========================================================
	// Handshake states.
	typedef enum logic [1:0] {
		IGF_IDLE,
		IGF_WAIT_ACK,
		IGF_GRANTED,
		IGF_RELEASE
	} igf_state_t;
	// Request pair as it leaves the block.
	typedef struct packed {
		logic buffer_flush_request_n;
		logic memory_request_n;
	} igf_req_pair_t;
	// PCI address phase as sampled.
	typedef struct packed {
		logic              frame_n;
		logic [ADDR_W-1:0] addr;
	} igf_addr_phase_t;
endpackage
`default_nettype wire

// ==== design/igf_req_driver.sv ====
`default_nettype none
module igf_req_driver (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire igf_pkg::igf_req_pair_t req_next,
	output var  igf_pkg::igf_req_pair_t req_out,
	output var  logic                   req_oe
);
	// ==========================================================
	// Enable register oe_reg, not used for req_oe: off from the start of reset, on from the first clock edge after its release.
	logic oe_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oe_reg <= 1'h0;
		end else begin
			oe_reg <= 1'h1;
		end
	end
	// ==========================================================
	// Request flip-flops sit at the inactive level through reset.
	igf_pkg::igf_req_pair_t req_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			req_reg <= {igf_pkg::REQ_INACTIVE, igf_pkg::REQ_INACTIVE};
		end else begin
			req_reg <= req_next;
		end
	end
	// Enable follows the reset level directly so release drives inactive at once.
	assign req_oe  = ~rst;
	assign req_out = req_reg;
endmodule
`default_nettype wire

// ==== design/igf_mem_decode.sv ====
`default_nettype none
module igf_mem_decode #(
	parameter int ADDR_W = igf_pkg::ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              frame_n,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [ADDR_W-1:0] range_base,
	input  wire logic [ADDR_W-1:0] range_mask,
	output var  logic              main_mem_select_n
);
	// ==========================================================
	// Address phase detection: first cycle with FRAME# newly low.
	logic frame_n_reg;
	logic sel_reg;
	logic addr_phase;
	logic hit;
	assign addr_phase = ~frame_n & frame_n_reg;
	assign hit        = ((addr ^ range_base) & range_mask) == '0;
	// Select is driven one clock after the address phase, for one clock.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_n_reg <= 1'h1;
			sel_reg     <= igf_pkg::SEL_INACTIVE;
		end else begin
			frame_n_reg <= frame_n;
			sel_reg     <= (addr_phase & hit) ? igf_pkg::SEL_ACTIVE
				: igf_pkg::SEL_INACTIVE;
		end
	end
	assign main_mem_select_n = sel_reg;
endmodule
`default_nettype wire

// ==== design/igf_handshake.sv ====
`default_nettype none
module igf_handshake #(
	parameter int ADDR_W = igf_pkg::ADDR_W
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              guaranteed_access_mode,
	input  wire logic              isa_bus_request,
	output var  logic              isa_bus_grant,
	input  wire logic              memory_acknowledge_n,
	output var  logic              memory_request_n,
	output var  logic              memory_request_oe,
	output var  logic              buffer_flush_request_n,
	output var  logic              buffer_flush_request_oe,
	input  wire logic              frame_n,
	input  wire logic [ADDR_W-1:0] pci_addr,
	input  wire logic [ADDR_W-1:0] mem_range_base,
	input  wire logic [ADDR_W-1:0] mem_range_mask,
	output var  logic              main_mem_select_n
);
	// ==========================================================
	// Elaboration check.
	if (ADDR_W < 1) begin : g_bad_width
		$error("ADDR_W must be at least one");
	end
	// ==========================================================
	// State and captured mode.
	igf_pkg::igf_state_t state_reg;
	igf_pkg::igf_state_t state_next;
	logic                mode_reg;
	logic                mode_next;
	logic                grant_reg;
	logic                grant_next;
	logic                req_oe;
	igf_pkg::igf_req_pair_t pair_next;
	igf_pkg::igf_req_pair_t pair_out;
	// ==========================================================
	// Decoded conditions.
	wire idle_now   = state_reg == igf_pkg::IGF_IDLE;
	wire start_req  = idle_now & isa_bus_request;
	wire ack_seen   = ~memory_acknowledge_n;
	wire requesting = state_next == igf_pkg::IGF_WAIT_ACK
		|| state_next == igf_pkg::IGF_GRANTED;
	// Mode is latched when a request starts and held until the next request starts.
	assign mode_next = start_req ? guaranteed_access_mode : mode_reg;
	// ==========================================================
	// Next state logic.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			igf_pkg::IGF_IDLE: begin
				if (isa_bus_request) begin
					state_next = igf_pkg::IGF_WAIT_ACK;
				end
			end
			igf_pkg::IGF_WAIT_ACK: begin
				if (!isa_bus_request) begin
					state_next = igf_pkg::IGF_RELEASE;
				end else if (ack_seen) begin
					state_next = igf_pkg::IGF_GRANTED;
				end
			end
			igf_pkg::IGF_GRANTED: begin
				if (!isa_bus_request) begin
					state_next = igf_pkg::IGF_RELEASE;
				end
			end
			igf_pkg::IGF_RELEASE: begin
				// Wait for the host to drop its acknowledge before a new request.
				if (!ack_seen) begin
					state_next = igf_pkg::IGF_IDLE;
				end
			end
			default: begin
				state_next = igf_pkg::IGF_IDLE;
			end
		endcase
	end
	// ==========================================================
	// Request pair: flush alone, or both in guaranteed mode; never memory alone.
	assign pair_next.buffer_flush_request_n = ~requesting;
	assign pair_next.memory_request_n       = ~(requesting & mode_next);
	// Grant only once acknowledge has been sampled.
	assign grant_next = state_next == igf_pkg::IGF_GRANTED;
	// ==========================================================
	// State registers.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= igf_pkg::IGF_IDLE;
			mode_reg  <= 1'h0;
			grant_reg <= 1'h0;
		end else begin
			state_reg <= state_next;
			mode_reg  <= mode_next;
			grant_reg <= grant_next;
		end
	end
	assign isa_bus_grant = grant_reg;
	// ==========================================================
	// Request pin driver.
	igf_req_driver u_req (
		.clk      (clk),
		.rst      (rst),
		.req_next (pair_next),
		.req_out  (pair_out),
		.req_oe   (req_oe)
	);
	assign buffer_flush_request_n  = pair_out.buffer_flush_request_n;
	assign memory_request_n        = pair_out.memory_request_n;
	assign buffer_flush_request_oe = req_oe;
	assign memory_request_oe       = req_oe;
	// ==========================================================
	// Main memory select decode.
	igf_mem_decode #(
		.ADDR_W (ADDR_W)
	) u_dec (
		.clk               (clk),
		.rst               (rst),
		.frame_n           (frame_n),
		.addr              (pci_addr),
		.range_base        (mem_range_base),
		.range_mask        (mem_range_mask),
		.main_mem_select_n (main_mem_select_n)
	);
endmodule
`default_nettype wire

// ==== sim/igf_handshake_props.sv ====
`default_nettype none
// ==========================================================
// Checker for the request pair, the grant and the select pulse.
module igf_handshake_props #(
	parameter int ADDR_W = 32
) (
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              guaranteed_access_mode,
	input wire logic              isa_bus_request,
	input wire logic              isa_bus_grant,
	input wire logic              memory_acknowledge_n,
	input wire logic              memory_request_n,
	input wire logic              buffer_flush_request_n,
	input wire logic              buffer_flush_request_oe,
	input wire logic              frame_n,
	input wire logic [ADDR_W-1:0] pci_addr,
	input wire logic [ADDR_W-1:0] mem_range_base,
	input wire logic [ADDR_W-1:0] mem_range_mask,
	input wire logic              main_mem_select_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// Short aliases and the address hit of the current cycle.
	wire logic f = buffer_flush_request_n;
	wire logic m = memory_request_n;
	wire logic g = isa_bus_grant;
	wire logic hit = ((pci_addr ^ mem_range_base) & mem_range_mask) == '0;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_pair_not_reserved: assert property (!(f && !m))
		else $error("memory request seen without flush request");
	a_release_drives: assert property ($fell(rst) |-> buffer_flush_request_oe && f && m)
		else $error("request pins not driven idle after reset");
	a_req_answer: assert property (isa_bus_request && f && $past(f) && memory_acknowledge_n
		&& $past(memory_acknowledge_n) |=> !f && (m == !$past(guaranteed_access_mode)))
		else $error("request pair wrong after bus request");
	a_grant_after_ack: assert property ($rose(g) |-> $past(!memory_acknowledge_n))
		else $error("grant without acknowledge");
	a_grant_with_flush: assert property (g |-> !f)
		else $error("grant while flush not requested");
	a_drop_idle: assert property (!isa_bus_request && !f |=> f && m && !g)
		else $error("pair not idle after request dropped");
	a_sel_cause: assert property (!main_mem_select_n |-> $past(!frame_n) && $past(frame_n, 2)
		&& $past(hit))
		else $error("select without a hitting address phase");
	a_sel_answer: assert property (!frame_n && $past(frame_n) && hit |=> !main_mem_select_n)
		else $error("select missing after address phase");
	a_sel_pulse: assert property (!main_mem_select_n |=> main_mem_select_n)
		else $error("select longer than one cycle");
endmodule
bind igf_handshake igf_handshake_props #(.ADDR_W(ADDR_W)) igf_handshake_props_inst (.*);
`default_nettype wire

// ==== sim/igf_host_model.sv ====
`default_nettype none
// ==========================================================
// Host bridge model answering the flush request; it does not see the memory request.
module igf_host_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       flush_n,
	input  wire logic [2:0] lag,
	output var  logic       ack_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt;
	// Acknowledge after lag plus one cycles of flushing; release once the flush request is idle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 3'h0;
			ack_n <= 1'h1;
		end else if (flush_n === 1'h0) begin
			if (cnt == lag) ack_n <= 1'h0;
			else cnt <= cnt + 3'h1;
		end else begin
			cnt <= 3'h0;
			ack_n <= 1'h1;
		end
	end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`default_nettype none
// ==========================================================
// Testbench for the grant and flush handshake.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, gam = 0, req = 0, fr_n = 1, ack_n;
	logic [31:0] addr = 32'h0, base = 32'h000A0000, mask = 32'hFFFF0000;
	logic [2:0] lag = 3'h0;
	logic gnt, m_n, m_oe, f_n, f_oe, sel_n;
	int error_cnt = 0, checks_done = 0;
	wire logic f_w = f_oe ? f_n : 1'hz;
	igf_handshake igf_handshake_inst (.clk(clk), .rst(rst), .guaranteed_access_mode(gam),
		.isa_bus_request(req), .isa_bus_grant(gnt), .memory_acknowledge_n(ack_n),
		.memory_request_n(m_n), .memory_request_oe(m_oe), .buffer_flush_request_n(f_n),
		.buffer_flush_request_oe(f_oe), .frame_n(fr_n), .pci_addr(addr),
		.mem_range_base(base), .mem_range_mask(mask), .main_mem_select_n(sel_n));
	igf_host_model igf_host_model_inst (.clk(clk), .rst(rst), .flush_n(f_w), .lag(lag),
		.ack_n(ack_n));
	// Clock at 8 ns.
	initial forever #4 clk = ~clk;
	task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// One full handshake in the given mode with the given host lag.
	task automatic hs(input logic mode, input logic [2:0] l);
		gam = mode;
		lag = l;
		req = 1;
		@(negedge clk) chk("pair", {f_n, m_n}, {1'h0, !mode});
		for (int i = 0; i < 20 && gnt !== 1'h1; i++) @(negedge clk);
		chk("grant", {gnt, ack_n}, 2'h2);
		req = 0;
		@(negedge clk) chk("idle", {f_n, m_n, gnt}, 3'h6);
		repeat (3) @(negedge clk);
	endtask
	// One address phase held low for two cycles.
	task automatic frame(input logic [31:0] a, input logic hit);
		addr = a;
		fr_n = 0;
		@(negedge clk) chk("select", sel_n, !hit);
		@(negedge clk) chk("select end", sel_n, 1'h1);
		fr_n = 1;
		@(negedge clk);
	endtask
	// Reset checks, handshakes, decode and a reset during a request.
	initial begin
		repeat (10) @(negedge clk);
		chk("in reset", {f_oe, m_oe, gnt, sel_n}, 4'h1);
		rst = 0;
		#1 chk("released", {f_oe, m_oe, f_n, m_n}, 4'hF);
		@(negedge clk);
		for (int k = 0; k < 4; k++) hs(k[0], {k[1], 2'h0});
		frame(32'h000A1234, 1);
		frame(32'h000B0000, 0);
		req = 1;
		repeat (3) @(negedge clk);
		rst = 1;
		#1 chk("mid reset", {f_oe, m_oe, gnt, sel_n}, 4'h1);
		@(negedge clk) req = 0;
		rst = 0;
		@(negedge clk) chk("after", {f_oe, m_oe, f_n, m_n}, 4'hF);
		hs(1, 3'h2);
		close_out();
	end
	// Watchdog against a hang.
	initial begin
		#100000;
		error_cnt++;
		close_out();
	end
endmodule
`default_nettype wire
